//--- dcd_decoder.sv
// Instruction decoder between program fetch and the core datapath
// Contract
// (RULE1) 0x71xx decodes as load temp and move product, one word, one cycle
// (RULE2) 0x74xx decodes as load temp and subtract product, one word, one cycle
// (RULE3) 0xa3xx multiply-accumulate with move, constant second word, three cycles
// (RULE4) 1000 1011 1000 1xxx loads the current auxiliary register select
// (RULE5) 0x54xx decodes as plain multiply into the product register
// (RULE6) 0x50xx multiply adding prior product, one word, one cycle
// (RULE7) 0x51xx multiply subtracting prior product, one word, one cycle
// (RULE8) 0xa0xx normalizes the accumulator in one cycle
// (RULE9) 0xbe82 OR immediate shifted 16, constant second word, two cycles
// (RULE10) 0xbe03 copies product into accumulator, one word, one cycle
// (RULE11) 0x8axx pops stack top to data memory in one cycle
// (RULE12) 0xbe3c pushes low accumulator onto stack in one cycle
// (RULE13) 1110 11TP conditional return, four cycles taken, two not taken
// (RULE14) 0xbbxx repeats the next instruction by the low byte count
// (RULE15) 1001 1SHF stores high accumulator with three-bit shift
// (RULE16) 0x7cxx subtracts short constant from current auxiliary register
// (RULE17) 0xbe4x sets status bits; low nibble 1101 raises external flag
// (RULE18) 0xbfxx sets product shift mode from the low field
// (RULE19) 0xaexx stores long immediate from second word in two cycles
// (RULE20) 0x66xx subtracts from low accumulator without sign extension
// (RULE21) 0xbe83 XOR immediate shifted 16, constant second word, two cycles
// (RULE22) 0x68xx zeroes low accumulator, loads high with rounding
// (RULE23) Two-word instructions hold word one and fetch operand before issue
`timescale 1ns/10ps
module dcd_decoder (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               instr_valid,
  input  wire logic [15:0]        instr_word,
  input  wire dcd_pkg::dcd_flags_s flags,
  output logic                    instr_ready,
  output logic                    op_valid,
  output dcd_pkg::dcd_issue_s     op_out,
  output logic                    external_flag_pin,
  output logic [2:0]              aux_register_select,
  output logic [1:0]              product_shift_mode,
  output logic [7:0]              repeat_count,
  output logic                    repeat_load
);

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_OPERAND = 3'b010,
    ST_STALL   = 3'b100
  } dcd_state_e;

  dcd_state_e         state;
  dcd_state_e         next_state;
  dcd_pkg::dcd_dec_s  dec;
  dcd_pkg::dcd_dec_s  held_dec;
  logic [15:0]        held_word;
  logic               accept;
  logic               issue;
  logic [15:0]        issue_word;
  logic [15:0]        issue_const;
  dcd_pkg::dcd_dec_s  issue_dec;
  logic               cond_true;
  logic [2:0]         issue_cycles;
  logic [2:0]         stall_len;
  logic               stall_last;

  // Maps a first word onto its operation, word count and cycle count
  function automatic dcd_pkg::dcd_dec_s decode(input logic [15:0] w);
    dcd_pkg::dcd_dec_s d;
    d = '{op: dcd_pkg::OP_UNKNOWN, two_word: 1'b0, cycles: dcd_pkg::CYC_ONE};
    if (w == dcd_pkg::OPC_OR16) begin
      d = '{dcd_pkg::OP_OR16, 1'b1, dcd_pkg::CYC_TWO}; // RULE9
    end else if (w == dcd_pkg::OPC_XOR16) begin
      d = '{dcd_pkg::OP_XOR16, 1'b1, dcd_pkg::CYC_TWO}; // RULE21
    end else if (w == dcd_pkg::OPC_PROD_ACC) begin
      d.op = dcd_pkg::OP_PROD_ACC; // RULE10
    end else if (w == dcd_pkg::OPC_PUSH) begin
      d.op = dcd_pkg::OP_PUSH; // RULE12
    end else if (w[15:4] == dcd_pkg::OPC_STATUS_SET) begin
      d.op = dcd_pkg::OP_STATUS_SET; // RULE17
    end else if (w[15:3] == dcd_pkg::OPC_AUX_PTR) begin
      d.op = dcd_pkg::OP_AUX_PTR; // RULE4
    end else if (w[15:11] == dcd_pkg::OPC_STORE_HI) begin
      d.op = dcd_pkg::OP_STORE_HI; // RULE15
    end else if (w[15:10] == dcd_pkg::OPC_COND_RET) begin
      d = '{dcd_pkg::OP_COND_RET, 1'b0, dcd_pkg::CYC_RET_SKIP}; // RULE13
    end else begin
      unique case (w[15:8])
        dcd_pkg::OPC_LDT_MOV: d.op = dcd_pkg::OP_LDT_MOV; // RULE1
        dcd_pkg::OPC_LDT_SUB: d.op = dcd_pkg::OP_LDT_SUB; // RULE2
        dcd_pkg::OPC_MAC_MOVE: d = '{dcd_pkg::OP_MAC_MOVE, 1'b1, dcd_pkg::CYC_THREE}; // RULE3
        dcd_pkg::OPC_MUL: d.op = dcd_pkg::OP_MUL; // RULE5
        dcd_pkg::OPC_MUL_ADD: d.op = dcd_pkg::OP_MUL_ADD; // RULE6
        dcd_pkg::OPC_MUL_SUB: d.op = dcd_pkg::OP_MUL_SUB; // RULE7
        dcd_pkg::OPC_NORMALIZE: d.op = dcd_pkg::OP_NORMALIZE; // RULE8
        dcd_pkg::OPC_POP_MEM: d.op = dcd_pkg::OP_POP_MEM; // RULE11
        dcd_pkg::OPC_REPEAT: d.op = dcd_pkg::OP_REPEAT; // RULE14
        dcd_pkg::OPC_AUX_SUB: d.op = dcd_pkg::OP_AUX_SUB; // RULE16
        dcd_pkg::OPC_SHIFT_MODE: d.op = dcd_pkg::OP_SHIFT_MODE; // RULE18
        dcd_pkg::OPC_STORE_IMM: d = '{dcd_pkg::OP_STORE_IMM, 1'b1, dcd_pkg::CYC_TWO}; // RULE19
        dcd_pkg::OPC_SUB_NOEXT: d.op = dcd_pkg::OP_SUB_NOEXT; // RULE20
        dcd_pkg::OPC_ZERO_RND: d.op = dcd_pkg::OP_ZERO_RND; // RULE22
        default:           d.op = dcd_pkg::OP_UNKNOWN;
      endcase
    end
    return d;
  endfunction

  // Handshake and which word is being issued
  assign instr_ready = (state == ST_IDLE) || (state == ST_OPERAND);
  assign accept      = instr_valid && instr_ready;
  assign dec         = decode(instr_word);
  assign issue       = accept && ((state == ST_OPERAND) || !dec.two_word); // RULE23
  assign issue_word  = (state == ST_OPERAND) ? held_word : instr_word;
  assign issue_dec   = (state == ST_OPERAND) ? held_dec : dec;
  assign issue_const = (state == ST_OPERAND) ? instr_word : 16'h0000;

  // Condition test: masked flag compare and the selected pin or flag test
  always_comb begin
    logic [3:0] mask;
    logic [3:0] want;
    logic [3:0] have;
    logic       test_ok;
    test_ok = 1'b0;
    mask    = instr_word[7:4];
    want    = instr_word[3:0];
    have    = {flags.z, flags.l, flags.v, flags.c};
    unique case (instr_word[9:8])
      dcd_pkg::TEST_BIO: test_ok = flags.bio_low;
      dcd_pkg::TEST_TC1: test_ok = flags.tc;
      dcd_pkg::TEST_TC0: test_ok = !flags.tc;
      default:           test_ok = 1'b1;
    endcase
    cond_true = test_ok && ((mask & (have ^ want)) == 4'h0); // RULE13
  end

  // Cycle count of the issued operation and the stall that follows it
  always_comb begin
    issue_cycles = issue_dec.cycles;
    if ((issue_dec.op == dcd_pkg::OP_COND_RET) && cond_true) begin
      issue_cycles = dcd_pkg::CYC_RET_TAKEN; // RULE13
    end
    stall_len = issue_cycles - (issue_dec.two_word ? 3'h2 : 3'h1); // RULE3
  end

  // Sequencer state
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (accept && dec.two_word) begin
          next_state = ST_OPERAND; // RULE23
        end else if (issue && (stall_len != 3'h0)) begin
          next_state = ST_STALL;
        end
      end
      ST_OPERAND: begin
        if (issue) begin
          next_state = (stall_len != 3'h0) ? ST_STALL : ST_IDLE;
        end
      end
      ST_STALL: begin
        if (stall_last) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  dcd_stall_counter u_stall (
    .clock (clock),
    .reset (reset),
    .load  (issue && (stall_len != 3'h0)),
    .count (stall_len),
    .last  (stall_last)
  );

  // First word of a two-word instruction is held until its operand arrives
  always_ff @(posedge clock) begin
    if (reset) begin
      held_word <= 16'h0000;
      held_dec  <= '{dcd_pkg::OP_UNKNOWN, 1'b0, dcd_pkg::CYC_ONE};
    end else if (accept && (state == ST_IDLE) && dec.two_word) begin
      held_word <= instr_word; // RULE23
      held_dec  <= dec;
    end
  end

  // Issued operation, one-cycle valid
  always_ff @(posedge clock) begin
    if (reset) begin
      op_valid <= 1'b0;
      op_out   <= '0;
    end else begin
      op_valid <= issue;
      if (issue) begin
        op_out.op      <= issue_dec.op;
        op_out.addr    <= issue_word[7:0];
        op_out.operand <= issue_const; // RULE9 RULE19 RULE21
        op_out.shift   <= issue_word[10:8]; // RULE15
        op_out.cycles  <= issue_cycles;
        op_out.taken   <= (issue_dec.op == dcd_pkg::OP_COND_RET) && cond_true;
      end
    end
  end

  // External flag from the status group
  always_ff @(posedge clock) begin
    if (reset) begin
      external_flag_pin <= 1'b0;
    end else if (issue && (issue_dec.op == dcd_pkg::OP_STATUS_SET)) begin
      if (issue_word[3:0] == dcd_pkg::FLAG_SET_SEL) begin
        external_flag_pin <= 1'b1; // RULE17
      end else if (issue_word[3:0] == dcd_pkg::FLAG_CLR_SEL) begin
        external_flag_pin <= 1'b0;
      end
    end
  end

  // Current auxiliary register select
  always_ff @(posedge clock) begin
    if (reset) begin
      aux_register_select <= dcd_pkg::AUX_RESET;
    end else if (issue && (issue_dec.op == dcd_pkg::OP_AUX_PTR)) begin
      aux_register_select <= issue_word[2:0]; // RULE4
    end
  end

  // Product shift mode
  always_ff @(posedge clock) begin
    if (reset) begin
      product_shift_mode <= dcd_pkg::PSHM_RESET;
    end else if (issue && (issue_dec.op == dcd_pkg::OP_SHIFT_MODE)) begin
      product_shift_mode <= issue_word[1:0]; // RULE18
    end
  end

  // Repeat count handed to the fetch unit
  always_ff @(posedge clock) begin
    if (reset) begin
      repeat_count <= dcd_pkg::REPEAT_RESET;
      repeat_load  <= 1'b0;
    end else begin
      repeat_load <= issue && (issue_dec.op == dcd_pkg::OP_REPEAT);
      if (issue && (issue_dec.op == dcd_pkg::OP_REPEAT)) begin
        repeat_count <= issue_word[7:0]; // RULE14
      end
    end
  end

  // Checks
  chk_move_product_decode: assert property (@(posedge clock) disable iff (reset) // RULE1
    accept && state == ST_IDLE && instr_word[15:8] == 8'h71
    |=> op_valid && op_out.op == dcd_pkg::OP_LDT_MOV && op_out.cycles == 3'h1)
    else $error("load temp move product misdecoded");

  chk_mac_move_timing: assert property (@(posedge clock) disable iff (reset) // RULE3
    op_valid && op_out.op == dcd_pkg::OP_MAC_MOVE |-> !instr_ready ##1 instr_ready)
    else $error("multiply accumulate with move stall wrong");

  chk_operand_fetch: assert property (@(posedge clock) disable iff (reset) // RULE23
    accept && state == ST_OPERAND |=> op_valid && op_out.operand == $past(instr_word))
    else $error("second word not issued as operand");

  chk_two_word_hold: assert property (@(posedge clock) disable iff (reset) // RULE23
    accept && state == ST_IDLE && instr_word == 16'hbe82
    |=> !op_valid && state == ST_OPERAND)
    else $error("two word instruction issued early");

  chk_aux_select: assert property (@(posedge clock) disable iff (reset) // RULE4
    accept && state == ST_IDLE && instr_word[15:3] == 13'h1171
    |=> aux_register_select == $past(instr_word[2:0]))
    else $error("auxiliary select not loaded");

  chk_ret_taken: assert property (@(posedge clock) disable iff (reset) // RULE13
    op_valid && op_out.op == dcd_pkg::OP_COND_RET && op_out.taken
    |-> !instr_ready [*3] ##1 instr_ready)
    else $error("taken return not four cycles");

  chk_ret_skipped: assert property (@(posedge clock) disable iff (reset) // RULE13
    op_valid && op_out.op == dcd_pkg::OP_COND_RET && !op_out.taken
    |-> op_out.cycles == 3'h2 && !instr_ready ##1 instr_ready)
    else $error("skipped return not two cycles");

  chk_flag_set: assert property (@(posedge clock) disable iff (reset) // RULE17
    accept && state == ST_IDLE && instr_word == 16'hbe4d |=> external_flag_pin)
    else $error("external flag not raised");

  chk_repeat_load: assert property (@(posedge clock) disable iff (reset) // RULE14
    accept && state == ST_IDLE && instr_word[15:8] == 8'hbb
    |=> repeat_load && repeat_count == $past(instr_word[7:0]))
    else $error("repeat count not loaded");

  chk_shift_mode: assert property (@(posedge clock) disable iff (reset) // RULE18
    accept && state == ST_IDLE && instr_word[15:8] == 8'hbf
    |=> product_shift_mode == $past(instr_word[1:0]))
    else $error("product shift mode not set");

  chk_store_high: assert property (@(posedge clock) disable iff (reset) // RULE15
    accept && state == ST_IDLE && instr_word[15:11] == 5'h13
    |=> op_out.op == dcd_pkg::OP_STORE_HI && op_out.shift == $past(instr_word[10:8]))
    else $error("store high shift field wrong");

endmodule

//--- dcd_decoder_tb.sv
// Self-checking testbench of the opcode decoder with a fetch model and a reference decode
`timescale 1ns/10ps
module dcd_decoder_tb;
  logic                clock = 1'b0;
  logic                reset;
  logic                gap;
  logic                slow;
  logic                instr_valid;
  logic [15:0]         instr_word;
  dcd_pkg::dcd_flags_s flags;
  logic                instr_ready;
  logic                op_valid;
  dcd_pkg::dcd_issue_s op_out;
  logic                external_flag_pin;
  logic [2:0]          aux_register_select;
  logic [1:0]          product_shift_mode;
  logic [7:0]          repeat_count;
  logic                repeat_load;
  logic [31:0]         seed;
  int                  n_fail;
  int                  num_checks;
  dcd_pkg::dcd_issue_s e;
  dcd_pkg::dcd_issue_s eq[$];
  int                  sq[$];
  dcd_pkg::dcd_flags_s hf;
  logic [15:0]         held;
  logic                pend, due, was_rst, flag_exp;
  logic [2:0]          aux;
  logic [1:0]          psm;
  logic [7:0]          rcnt;
  int                  stall;
  logic [7:0]          tbl [16] = '{8'h71, 8'h74, 8'ha3, 8'h54, 8'h50, 8'h51, 8'ha0, 8'h8a,
                                    8'hbb, 8'h7c, 8'hbf, 8'hae, 8'h66, 8'h68, 8'hbe, 8'h8b};
  logic [15:0]         corner [] = '{16'h71ab, 16'h74ff, 16'ha312, 16'h1234, 16'ha312, 16'ha312,
    16'h8b8f, 16'h8b88, 16'h8b80, 16'h5400, 16'h50ff, 16'h5101, 16'ha000, 16'hbe82, 16'hffff,
    16'hbe03, 16'h8aff, 16'hbe3c, 16'hef00, 16'hecf0, 16'hee0f, 16'hed55, 16'he800, 16'hbb00,
    16'hbbff, 16'h9f34, 16'h9812, 16'h9000, 16'h7c80, 16'hbe4d, 16'hbe4f, 16'hbe4c, 16'hbf03,
    16'hbf02, 16'hae00, 16'h0000, 16'h6612, 16'h6834, 16'hbe83, 16'h5a5a, 16'h0000, 16'hbe4d};

  dcd_decoder i_dut (
    .clock               (clock),
    .reset               (reset),
    .instr_valid         (instr_valid),
    .instr_word          (instr_word),
    .flags               (flags),
    .instr_ready         (instr_ready),
    .op_valid            (op_valid),
    .op_out              (op_out),
    .external_flag_pin   (external_flag_pin),
    .aux_register_select (aux_register_select),
    .product_shift_mode  (product_shift_mode),
    .repeat_count        (repeat_count),
    .repeat_load         (repeat_load)
  );

  dcd_fetch_model i_fetch (
    .clock       (clock),
    .reset       (reset),
    .gap         (gap),
    .instr_ready (instr_ready),
    .instr_valid (instr_valid),
    .instr_word  (instr_word)
  );

  // Pseudo-random step
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Words that take a constant second word
  function automatic logic tw(input logic [15:0] w);
    return w[15:8] == dcd_pkg::OPC_MAC_MOVE || w[15:8] == dcd_pkg::OPC_STORE_IMM ||
           w == dcd_pkg::OPC_OR16 || w == dcd_pkg::OPC_XOR16;
  endfunction

  // Expected issue for a first word under the given flags
  function automatic dcd_pkg::dcd_issue_s model(input logic [15:0] w,
                                                input dcd_pkg::dcd_flags_s f);
    dcd_pkg::dcd_issue_s r;
    logic                tst;
    r = '0;
    r.addr = w[7:0];
    r.shift = w[10:8];
    r.cycles = dcd_pkg::CYC_ONE;
    tst = w[9:8] == 2'h0 ? f.bio_low : w[9:8] == 2'h1 ? f.tc : w[9:8] == 2'h2 ? !f.tc : 1'b1;
    if (w == dcd_pkg::OPC_OR16 || w == dcd_pkg::OPC_XOR16) begin
      r.op = w[0] ? dcd_pkg::OP_XOR16 : dcd_pkg::OP_OR16;
      r.cycles = dcd_pkg::CYC_TWO;
    end else if (w == dcd_pkg::OPC_PROD_ACC) r.op = dcd_pkg::OP_PROD_ACC;
    else if (w == dcd_pkg::OPC_PUSH) r.op = dcd_pkg::OP_PUSH;
    else if (w[15:4] == dcd_pkg::OPC_STATUS_SET) r.op = dcd_pkg::OP_STATUS_SET;
    else if (w[15:3] == dcd_pkg::OPC_AUX_PTR) r.op = dcd_pkg::OP_AUX_PTR;
    else if (w[15:11] == dcd_pkg::OPC_STORE_HI) r.op = dcd_pkg::OP_STORE_HI;
    else if (w[15:10] == dcd_pkg::OPC_COND_RET) begin
      r.op = dcd_pkg::OP_COND_RET;
      r.taken = tst && (((w[3:0] ^ {f.z, f.l, f.v, f.c}) & w[7:4]) == 4'h0);
      r.cycles = r.taken ? dcd_pkg::CYC_RET_TAKEN : dcd_pkg::CYC_RET_SKIP;
    end else begin
      case (w[15:8])
        dcd_pkg::OPC_LDT_MOV: r.op = dcd_pkg::OP_LDT_MOV;
        dcd_pkg::OPC_LDT_SUB: r.op = dcd_pkg::OP_LDT_SUB;
        dcd_pkg::OPC_MUL: r.op = dcd_pkg::OP_MUL;
        dcd_pkg::OPC_MUL_ADD: r.op = dcd_pkg::OP_MUL_ADD;
        dcd_pkg::OPC_MUL_SUB: r.op = dcd_pkg::OP_MUL_SUB;
        dcd_pkg::OPC_NORMALIZE: r.op = dcd_pkg::OP_NORMALIZE;
        dcd_pkg::OPC_POP_MEM: r.op = dcd_pkg::OP_POP_MEM;
        dcd_pkg::OPC_REPEAT: r.op = dcd_pkg::OP_REPEAT;
        dcd_pkg::OPC_AUX_SUB: r.op = dcd_pkg::OP_AUX_SUB;
        dcd_pkg::OPC_SHIFT_MODE: r.op = dcd_pkg::OP_SHIFT_MODE;
        dcd_pkg::OPC_SUB_NOEXT: r.op = dcd_pkg::OP_SUB_NOEXT;
        dcd_pkg::OPC_ZERO_RND: r.op = dcd_pkg::OP_ZERO_RND;
        dcd_pkg::OPC_MAC_MOVE: begin
          r.op = dcd_pkg::OP_MAC_MOVE;
          r.cycles = dcd_pkg::CYC_THREE;
        end
        dcd_pkg::OPC_STORE_IMM: begin
          r.op = dcd_pkg::OP_STORE_IMM;
          r.cycles = dcd_pkg::CYC_TWO;
        end
        default: r.op = dcd_pkg::OP_UNKNOWN;
      endcase
    end
    return r;
  endfunction

  // Compare one value and count the outcome
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Wait until the fetch model has delivered everything
  task automatic drain();
    for (int i = 0; i < 8000; i++) begin
      if (i_fetch.q.size() == 0 && !instr_valid) break;
      @(posedge clock);
    end
    repeat (8) @(posedge clock);
  endtask

  // Core clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Random flags and fetch gaps on the falling edge
  always @(negedge clock) begin
    seed = xs(seed);
    flags <= dcd_pkg::dcd_flags_s'(seed[5:0]);
    gap <= slow & seed[7];
  end

  // Reference monitor: issue timing, contents, stalls and side outputs
  always @(posedge clock) begin
    if (reset) begin
      pend = 1'b0;
      due = 1'b0;
      was_rst = 1'b1;
      stall = 0;
      flag_exp = 1'b0;
      aux = dcd_pkg::AUX_RESET;
      psm = dcd_pkg::PSHM_RESET;
      rcnt = dcd_pkg::REPEAT_RESET;
      eq.delete();
      sq.delete();
    end else begin
      if (was_rst) check("op_out after reset", 64'(op_out), 64'h0);
      was_rst = 1'b0;
      check("op_valid", 64'(op_valid), 64'(due));
      if (due) begin
        e = eq.pop_front();
        stall = sq.pop_front();
        check("op_out", 64'(op_out), 64'(e));
        if (e.op == dcd_pkg::OP_STATUS_SET) begin
          if (e.addr[3:0] == dcd_pkg::FLAG_SET_SEL) flag_exp = 1'b1;
          if (e.addr[3:0] == dcd_pkg::FLAG_CLR_SEL) flag_exp = 1'b0;
        end
        if (e.op == dcd_pkg::OP_AUX_PTR) aux = e.addr[2:0];
        if (e.op == dcd_pkg::OP_SHIFT_MODE) psm = e.addr[1:0];
        if (e.op == dcd_pkg::OP_REPEAT) rcnt = e.addr;
      end
      check("instr_ready", 64'(instr_ready), 64'(stall == 0));
      check("repeat_load", 64'(repeat_load), 64'(due && e.op == dcd_pkg::OP_REPEAT));
      check("external_flag_pin", 64'(external_flag_pin), 64'(flag_exp));
      check("aux_register_select", 64'(aux_register_select), 64'(aux));
      check("product_shift_mode", 64'(product_shift_mode), 64'(psm));
      check("repeat_count", 64'(repeat_count), 64'(rcnt));
      if (stall > 0) stall--;
      due = 1'b0;
      if (instr_valid && instr_ready) begin
        if (pend) begin
          e = model(held, hf);
          e.operand = instr_word;
          eq.push_back(e);
          sq.push_back(int'(e.cycles) - 2);
          pend = 1'b0;
          due = 1'b1;
        end else if (tw(instr_word)) begin
          held = instr_word;
          hf = flags;
          pend = 1'b1;
        end else begin
          e = model(instr_word, flags);
          eq.push_back(e);
          sq.push_back(int'(e.cycles) - 1);
          due = 1'b1;
        end
      end
    end
  end

  // Watchdog against a hung handshake
  initial begin
    #(30000 * 5);
    n_fail++;
    final_report();
  end

  // Main sequence: corner words back to back, abandoned pairing, then random traffic
  initial begin
    int n;
    reset = 1'b1;
    flags = '0;
    gap = 1'b0;
    slow = 1'b0;
    seed = 32'hd30b;
    n_fail = 0;
    num_checks = 0;
    repeat (4) @(negedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    foreach (corner[k]) i_fetch.put(corner[k]);
    drain();
    i_fetch.put(16'ha312);
    for (n = 0; n < 50; n++) begin
      if (pend) break;
      @(posedge clock);
    end
    @(negedge clock);
    reset <= 1'b1;
    repeat (2) @(negedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    i_fetch.put(16'h71ab);
    drain();
    slow = 1'b1;
    for (n = 0; n < 500; n++) begin
      seed = xs(seed);
      i_fetch.put(seed[0] ? {tbl[seed[4:1]], seed[15:8]} : seed[31:16]);
    end
    drain();
    final_report();
  end
endmodule

//--- dcd_fetch_model.sv
// Program fetch model that offers queued words to the decoder with a valid/ready handshake
`timescale 1ns/10ps
module dcd_fetch_model (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        gap,
  input  wire logic        instr_ready,
  output logic             instr_valid,
  output logic [15:0]      instr_word
);
  logic [15:0] q[$];
  logic        took;

  // Idle state at time zero
  initial begin
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    took = 1'b0;
  end

  // Queue one program word for delivery
  task automatic put(input logic [15:0] w);
    q.push_back(w);
  endtask

  // Note whether the offered word was taken at this edge
  always @(posedge clock) begin
    took <= instr_valid && instr_ready;
  end

  // Word held until taken; a released bus toggles so no stale value looks valid
  always @(negedge clock) begin
    if (reset) begin
      q.delete();
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
    end else if (!instr_valid || took) begin
      if (q.size() != 0 && !gap) begin
        instr_valid <= 1'b1;
        instr_word <= q.pop_front();
      end else begin
        instr_valid <= 1'b0;
        instr_word <= ~instr_word;
      end
    end
  end
endmodule

//--- dcd_pkg.sv
// Package with opcode patterns, timing counts and carrier types of the opcode decoder
package dcd_pkg;

  // Upper-byte opcode patterns, addressing or constant field in the low byte
  localparam logic [7:0] OPC_LDT_MOV    = 8'h71;
  localparam logic [7:0] OPC_LDT_SUB    = 8'h74;
  localparam logic [7:0] OPC_MAC_MOVE   = 8'ha3;
  localparam logic [7:0] OPC_MUL        = 8'h54;
  localparam logic [7:0] OPC_MUL_ADD    = 8'h50;
  localparam logic [7:0] OPC_MUL_SUB    = 8'h51;
  localparam logic [7:0] OPC_NORMALIZE  = 8'ha0;
  localparam logic [7:0] OPC_POP_MEM    = 8'h8a;
  localparam logic [7:0] OPC_REPEAT     = 8'hbb;
  localparam logic [7:0] OPC_AUX_SUB    = 8'h7c;
  localparam logic [7:0] OPC_SHIFT_MODE = 8'hbf;
  localparam logic [7:0] OPC_STORE_IMM  = 8'hae;
  localparam logic [7:0] OPC_SUB_NOEXT  = 8'h66;
  localparam logic [7:0] OPC_ZERO_RND   = 8'h68;
  // Partial patterns compared against the top bits of the word
  localparam logic [4:0]  OPC_STORE_HI   = 5'h13;
  localparam logic [5:0]  OPC_COND_RET   = 6'h3b;
  localparam logic [11:0] OPC_STATUS_SET = 12'hbe4;
  localparam logic [12:0] OPC_AUX_PTR    = 13'h1171;
  // Full 16-bit patterns
  localparam logic [15:0] OPC_OR16  = 16'hbe82;
  localparam logic [15:0] OPC_XOR16 = 16'hbe83;
  localparam logic [15:0] OPC_PROD_ACC = 16'hbe03;
  localparam logic [15:0] OPC_PUSH  = 16'hbe3c;
  // Status group low nibbles driving the external flag
  localparam logic [3:0] FLAG_SET_SEL = 4'hd;
  localparam logic [3:0] FLAG_CLR_SEL = 4'hc;
  // Test selections of the conditional return
  localparam logic [1:0] TEST_BIO = 2'h0;
  localparam logic [1:0] TEST_TC1 = 2'h1;
  localparam logic [1:0] TEST_TC0 = 2'h2;
  // Cycle counts per instruction class
  localparam logic [2:0] CYC_ONE       = 3'h1;
  localparam logic [2:0] CYC_TWO       = 3'h2;
  localparam logic [2:0] CYC_THREE     = 3'h3;
  localparam logic [2:0] CYC_RET_TAKEN = 3'h4;
  localparam logic [2:0] CYC_RET_SKIP  = 3'h2;
  // Reset values
  localparam logic [2:0] AUX_RESET  = 3'h0;
  localparam logic [1:0] PSHM_RESET = 2'h0;
  localparam logic [7:0] REPEAT_RESET = 8'h00;

  typedef enum logic [4:0] {
    OP_UNKNOWN, OP_LDT_MOV, OP_LDT_SUB, OP_MAC_MOVE, OP_AUX_PTR, OP_MUL, OP_MUL_ADD,
    OP_MUL_SUB, OP_NORMALIZE, OP_OR16, OP_PROD_ACC, OP_POP_MEM, OP_PUSH, OP_COND_RET,
    OP_REPEAT, OP_STORE_HI, OP_AUX_SUB, OP_STATUS_SET, OP_SHIFT_MODE, OP_STORE_IMM,
    OP_SUB_NOEXT, OP_XOR16, OP_ZERO_RND
  } dcd_op_e;

  // Condition inputs sampled from the datapath
  typedef struct packed {
    logic z;
    logic l;
    logic v;
    logic c;
    logic tc;
    logic bio_low;
  } dcd_flags_s;

  // Result of decoding one first word
  typedef struct packed {
    dcd_op_e    op;
    logic       two_word;
    logic [2:0] cycles;
  } dcd_dec_s;

  // Operation issued to the datapath
  typedef struct packed {
    dcd_op_e     op;
    logic [7:0]  addr;
    logic [15:0] operand;
    logic [2:0]  shift;
    logic [2:0]  cycles;
    logic        taken;
  } dcd_issue_s;

endpackage

//--- dcd_stall_counter.sv
// Down counter that marks the last cycle of an execution stall
`timescale 1ns/10ps
module dcd_stall_counter (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       load,
  input  wire logic [2:0] count,
  output logic            last
);

  logic [2:0] remain;

  // Load the stall length, then count down to zero
  always_ff @(posedge clock) begin
    if (reset) begin
      remain <= 3'h0;
    end else if (load) begin
      remain <= count;
    end else if (remain != 3'h0) begin
      remain <= remain - 3'h1;
    end
  end

  assign last = (remain == 3'h1);

endmodule
